//--- common/adcs_pkg.sv
package adcs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TCY_NS = 80;
  localparam int CLK_NS = 20;
  localparam int TCY_CYCLES = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_TAD = 11;
  localparam int WAIT_TAD = 2;
  localparam int RC_DIV = 200;
  localparam logic [2:0] ACQ_NONE = 3'h0;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [7:0] PORT_RST = 8'h00;
  typedef enum logic [2:0] {ST_SAMPLE, ST_DELAY, ST_ACQ, ST_CONV, ST_WAIT} adcs_state_e;
endpackage

//--- hw/adcs_sequencer.sv
// Function
// - hold capacitor disconnects from pin when conversion phase begins
// - acquisition select 000: go starts conversion after one instruction cycle, software times acquisition
// - nonzero acquisition select: keep sampling programmed bit periods, then convert
// - on completion clear go, set done flag, resume sampling selected channel
// - go does not separate acquisition end from conversion start and stays set; SAMPLE_ACTIVE_O clears at conversion start
// - each conversion lasts exactly eleven bit periods
// - clock select maps 2,4,8,16,32,64 oscillator periods or internal RC
// - acquisition select 000 delays conversion start by one instruction cycle
// - selected pin level converts regardless of its direction bit
// - port reads return zero for pins whose analog config bit is clear, and the pin level where it is set
// - clearing go during conversion aborts it immediately
// - aborted conversion leaves result pair unchanged
// - two bit periods wait after completion or abort, then acquisition restarts
// - acquisition select 010 samples four bit periods before converting
// - acquisition select maps to 0,2,4,6,8,12,16,20 bit periods
// - when enabled, go set means acquiring or converting, go clear means idle
// - justify bit set right justifies result, clear left justifies
// - reset returns the sequencer to its sample state and aborts any conversion
`timescale 1ns/1ps
`default_nettype none
module adcs_sequencer
  import adcs_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic CONVERTER_ENABLE_I,
  input wire logic GO_SET_I,
  input wire logic GO_CLEAR_I,
  input wire logic [2:0] ACQUISITION_TIME_SELECT_I,
  input wire logic [2:0] CONVERSION_CLOCK_SELECT_I,
  input wire logic RESULT_JUSTIFY_SELECT_I,
  input wire logic RESULT_WRITE_I,
  input wire logic [15:0] RESULT_WRITE_DATA_I,
  input wire logic [7:0] ANALOG_CONFIG_I,
  input wire logic [7:0] PORT_PIN_I,
  input wire logic COMPARE_I,
  input wire logic DONE_FLAG_CLEAR_I,
  output logic GO_O,
  output logic CONVERSION_DONE_IRQ_FLAG_O,
  output logic HOLD_CAPACITOR_CONNECT_O,
  output logic SAMPLE_ACTIVE_O,
  output logic [9:0] DAC_TRIAL_O,
  output logic [7:0] RESULT_HIGH_BYTE_O,
  output logic [7:0] RESULT_LOW_BYTE_O,
  output logic [7:0] PORT_READ_O
);
  import adcs_pkg::*;
  adcs_state_e state_q;
  adcs_state_e state_d;
  logic go_q;
  logic flag_q;
  logic [4:0] tad_cnt_q;
  logic [4:0] tad_cnt_d;
  logic [1:0] dly_q;
  logic [9:0] sar_q;
  logic [9:0] res_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [7:0] port_q;
  logic tad;
  logic run;
  logic abort;
  logic conv_end;
  logic acq_end;
  logic [4:0] acq_len;
  logic [3:0] bit_idx;
  logic [9:0] bit_mask;
  logic [9:0] sar_trial;
  logic [9:0] sar_next;

  function automatic logic [4:0] acq_tad(input logic [2:0] sel);
    case (sel)
      3'h0: acq_tad = 5'd0;
      3'h1: acq_tad = 5'd2;
      3'h2: acq_tad = 5'd4;
      3'h3: acq_tad = 5'd6;
      3'h4: acq_tad = 5'd8;
      3'h5: acq_tad = 5'd12;
      3'h6: acq_tad = 5'd16;
      default: acq_tad = 5'd20;
    endcase
  endfunction

  // an abort restarts the prescaler so the following wait is two full bit periods
  assign run = ((state_q == ST_ACQ) || (state_q == ST_CONV) || (state_q == ST_WAIT)) && !abort;
  adcs_tad_gen u_tad (
    .CLK_SYS_I(CLK_SYS_I),
    .SRST_I(SRST_I),
    .run_i(run),
    .clock_select_i(CONVERSION_CLOCK_SELECT_I),
    .tad_o(tad)
  );

  assign acq_len = acq_tad(ACQUISITION_TIME_SELECT_I);
  assign abort = GO_CLEAR_I && ((state_q == ST_ACQ) || (state_q == ST_CONV) || (state_q == ST_DELAY));
  assign acq_end = tad && (tad_cnt_q == acq_len - 5'd1);
  assign conv_end = tad && (tad_cnt_q == 5'(CONV_TAD - 1));
  assign bit_idx = 4'(CONV_TAD - 1) - 4'(tad_cnt_q);
  assign bit_mask = (tad_cnt_q >= 5'd1 && tad_cnt_q <= 5'd10) ? (10'h001 << bit_idx) : 10'h000;
  assign sar_trial = sar_q | bit_mask;
  // includes the decision of the current bit period, so the last bit reaches the result
  assign sar_next = (tad && bit_mask != 10'h000 && COMPARE_I) ? sar_trial : sar_q;

  always_comb
  begin
    state_d = state_q;
    tad_cnt_d = tad_cnt_q;
    if (tad)
      tad_cnt_d = tad_cnt_q + 5'd1;
    case (state_q)
      ST_SAMPLE:
        if (CONVERTER_ENABLE_I && GO_SET_I)
        begin
          tad_cnt_d = 5'd0;
          if (acq_len == 5'd0)
            state_d = ST_DELAY;
          else
            state_d = ST_ACQ;
        end
      ST_DELAY:
        if (dly_q == 2'(TCY_CYCLES - 1))
        begin
          state_d = ST_CONV;
          tad_cnt_d = 5'd0;
        end
      ST_ACQ:
        if (acq_end)
        begin
          state_d = ST_CONV;
          tad_cnt_d = 5'd0;
        end
      ST_CONV:
        if (conv_end)
        begin
          state_d = ST_WAIT;
          tad_cnt_d = 5'd0;
        end
      ST_WAIT:
        if (tad && tad_cnt_q == 5'(WAIT_TAD - 1))
          state_d = ST_SAMPLE;
      default:
        state_d = ST_SAMPLE;
    endcase
    if (abort)
    begin
      state_d = ST_WAIT;
      tad_cnt_d = 5'd0;
    end
    if (!CONVERTER_ENABLE_I)
      state_d = ST_SAMPLE;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      state_q <= ST_SAMPLE;
      tad_cnt_q <= 5'd0;
      dly_q <= 2'd0;
    end
    else
    begin
      state_q <= state_d;
      tad_cnt_q <= tad_cnt_d;
      dly_q <= (state_q == ST_DELAY) ? dly_q + 2'd1 : 2'd0;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      go_q <= 1'b0;
    else if (!CONVERTER_ENABLE_I || abort || (state_q == ST_CONV && conv_end))
      go_q <= 1'b0;
    else if (state_q == ST_SAMPLE && GO_SET_I)
      go_q <= 1'b1;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      flag_q <= 1'b0;
    else if (state_q == ST_CONV && conv_end && !abort)
      flag_q <= 1'b1;
    else if (DONE_FLAG_CLEAR_I)
      flag_q <= 1'b0;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      sar_q <= RESULT_RST;
    else if (state_q != ST_CONV)
      sar_q <= RESULT_RST;
    else
      sar_q <= sar_next;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      res_q <= RESULT_RST;
    else if (state_q == ST_CONV && conv_end && !abort)
      res_q <= sar_next;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
    begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end
    else if (state_q == ST_CONV && conv_end && !abort)
    begin
      hi_q <= RESULT_JUSTIFY_SELECT_I ? {6'h00, sar_next[9:8]} : sar_next[9:2];
      lo_q <= RESULT_JUSTIFY_SELECT_I ? sar_next[7:0] : {sar_next[1:0], 6'h00};
    end
    else if (RESULT_WRITE_I)
    begin
      hi_q <= RESULT_WRITE_DATA_I[15:8];
      lo_q <= RESULT_WRITE_DATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      port_q <= PORT_RST;
    else
      port_q <= PORT_PIN_I & ANALOG_CONFIG_I;
  end

  assign GO_O = go_q;
  assign CONVERSION_DONE_IRQ_FLAG_O = flag_q;
  assign HOLD_CAPACITOR_CONNECT_O = (state_q != ST_CONV);
  assign SAMPLE_ACTIVE_O = CONVERTER_ENABLE_I && (state_q == ST_SAMPLE || state_q == ST_ACQ
    || state_q == ST_DELAY);
  assign DAC_TRIAL_O = sar_trial;
  assign RESULT_HIGH_BYTE_O = hi_q;
  assign RESULT_LOW_BYTE_O = lo_q;
  assign PORT_READ_O = port_q;
endmodule
`default_nettype wire

//--- hw/adcs_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_tad_gen
  import adcs_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic run_i,
  input wire logic [2:0] clock_select_i,
  output logic tad_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] limit;
  function automatic logic [7:0] tad_div(input logic [2:0] sel);
    case (sel)
      3'h0: tad_div = 8'h02;
      3'h4: tad_div = 8'h04;
      3'h1: tad_div = 8'h08;
      3'h5: tad_div = 8'h10;
      3'h2: tad_div = 8'h20;
      3'h6: tad_div = 8'h40;
      default: tad_div = 8'(RC_DIV);
    endcase
  endfunction
  assign limit = tad_div(clock_select_i);
  assign tad_o = run_i && (cnt_q == limit - 8'h01);
  assign cnt_d = (!run_i || tad_o) ? 8'h00 : cnt_q + 8'h01;
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SRST_I)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

//--- sim/adcs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_model (
  input wire logic [9:0] level_i,
  input wire logic [9:0] trial_i,
  input wire logic hold_i,
  output logic compare_o
);
  logic [9:0] held;
  always @* if (hold_i) held = level_i;
  assign compare_o = held >= trial_i;
endmodule
`default_nettype wire

//--- sim/adcs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_sva (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic CONVERTER_ENABLE_I,
  input wire logic GO_SET_I,
  input wire logic GO_CLEAR_I,
  input wire logic GO_O,
  input wire logic CONVERSION_DONE_IRQ_FLAG_O,
  input wire logic HOLD_CAPACITOR_CONNECT_O,
  input wire logic [7:0] RESULT_HIGH_BYTE_O,
  input wire logic [7:0] RESULT_LOW_BYTE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  sequence conv_run;
    !HOLD_CAPACITOR_CONNECT_O && !GO_CLEAR_I && CONVERTER_ENABLE_I;
  endsequence
  sequence conv_end;
    HOLD_CAPACITOR_CONNECT_O && !GO_O;
  endsequence
  go_taken_a: assert property ($rose(GO_O) |-> $past(GO_SET_I) && $past(CONVERTER_ENABLE_I))
    else $error("go rose without request");
  hold_conv_a: assert property (!HOLD_CAPACITOR_CONNECT_O |-> GO_O)
    else $error("hold open while idle");
  conv_start_a: assert property ($fell(HOLD_CAPACITOR_CONNECT_O) |-> $past(GO_O, 4))
    else $error("conversion started early");
  done_flag_a: assert property (conv_run ##1 conv_end |-> CONVERSION_DONE_IRQ_FLAG_O)
    else $error("done flag not set");
  abort_go_a: assert property (GO_CLEAR_I && GO_O |=> !GO_O && HOLD_CAPACITOR_CONNECT_O)
    else $error("abort ignored");
  abort_keep_a: assert property (GO_CLEAR_I && !HOLD_CAPACITOR_CONNECT_O |=>
    $stable({RESULT_HIGH_BYTE_O, RESULT_LOW_BYTE_O}))
    else $error("result changed on abort");
  wait_gap_a: assert property ($fell(GO_O) |-> (!GO_O) [*4])
    else $error("restart inside wait");
  enable_off_a: assert property (!CONVERTER_ENABLE_I |=> !GO_O)
    else $error("go while disabled");
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adcs_pkg::*;
  logic clk = 0, rst = 1, en = 0, gs = 0, gc = 0, jst = 0, rw = 0, dc = 0, cmp, go, flg, hold, samp;
  logic [2:0] acq = 0, cs = 0;
  logic [15:0] wd = 0;
  logic [7:0] cfg = 0, pin = 0, rh, rl, prd;
  logic [9:0] lvl = 0, tri_v;
  int error_cnt = 0, total_checks = 0;
  int at[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  initial forever #10 clk = ~clk;
  adcs_analog_model am (.level_i(lvl), .trial_i(tri_v), .hold_i(hold), .compare_o(cmp));
  adcs_sequencer dut (.CLK_SYS_I(clk), .SRST_I(rst), .CONVERTER_ENABLE_I(en), .GO_SET_I(gs),
    .GO_CLEAR_I(gc), .ACQUISITION_TIME_SELECT_I(acq), .CONVERSION_CLOCK_SELECT_I(cs),
    .RESULT_JUSTIFY_SELECT_I(jst), .RESULT_WRITE_I(rw), .RESULT_WRITE_DATA_I(wd),
    .ANALOG_CONFIG_I(cfg), .PORT_PIN_I(pin), .COMPARE_I(cmp), .DONE_FLAG_CLEAR_I(dc),
    .GO_O(go), .CONVERSION_DONE_IRQ_FLAG_O(flg), .HOLD_CAPACITOR_CONNECT_O(hold),
    .SAMPLE_ACTIVE_O(samp), .DAC_TRIAL_O(tri_v), .RESULT_HIGH_BYTE_O(rh),
    .RESULT_LOW_BYTE_O(rl), .PORT_READ_O(prd));
  task tick;
    @(posedge clk);
    #1;
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  function int tad(input logic [2:0] c);
    case (c)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return RC_DIV;
    endcase
  endfunction
  task pulse_go;
    gs <= 1;
    tick;
    gs <= 0;
  endtask
  task run(input logic [2:0] a, input logic [2:0] c, input logic [9:0] v, input bit ab);
    int n, m, d, e;
    logic [15:0] old;
    d = tad(c);
    e = (a == 0) ? TCY_CYCLES : at[a] * d;
    acq <= a;
    cs <= c;
    lvl <= v;
    jst <= $urandom;
    tick;
    pulse_go;
    chk("go", go, 1);
    n = 0;
    while (hold !== 0 && n < 9000)
    begin
      tick;
      n++;
      gs <= (n == 2);
    end
    gs <= 0;
    chk("acq", n >= e && n <= e + d, 1);
    chk("go6", go, 1);
    chk("samp", samp, 0);
    old = {rh, rl};
    m = 0;
    if (ab)
    begin
      repeat (3) tick;
      gc <= 1;
      tick;
      gc <= 0;
      chk("abgo", go, 0);
      chk("abres", {rh, rl}, old);
    end
    else
    begin
      while (hold === 0 && m < 9000)
      begin
        tick;
        m++;
      end
      chk("conv", m, 11 * d);
      chk("done", {go, flg}, 2'h1);
      chk("res", {rh, rl}, jst ? {6'h00, v} : {v, 6'h00});
      dc <= 1;
      tick;
      dc <= 0;
      chk("clr", flg, 0);
    end
    if (n >= 9000 || m >= 9000) begin error_cnt++; conclude; end
    repeat (2 * d + 2) tick;
    chk("samp1", samp, 1);
  endtask
  initial
  begin
    logic [2:0] c;
    void'($urandom(32'ha5f9_ac27));
    repeat (20) tick;
    rst <= 0;
    tick;
    en <= 1;
    cfg <= $urandom;
    pin <= $urandom;
    wd <= $urandom;
    rw <= 1;
    tick;
    rw <= 0;
    tick;
    chk("port", prd, pin & cfg);
    chk("wr", {rh, rl}, wd);
    run(3'h0, 3'h0, 10'h3ff, 0);
    run(3'h0, 3'h3, $urandom, 0);
    run(3'h2, 3'h0, 10'h000, 0);
    run(3'h0, 3'h4, $urandom, 1);
    for (int i = 0; i < 10; i++)
    begin
      c = $urandom;
      if (c[1:0] == 2'h3) c = 3'h0;
      run(i[2:0], c, $urandom, i == 9);
    end
    pulse_go;
    en <= 0;
    tick;
    chk("off", go, 0);
    conclude;
  end
endmodule
bind adcs_sequencer adcs_sva u_sva (.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .CONVERTER_ENABLE_I(CONVERTER_ENABLE_I),
  .GO_SET_I(GO_SET_I), .GO_CLEAR_I(GO_CLEAR_I), .GO_O(GO_O), .CONVERSION_DONE_IRQ_FLAG_O(CONVERSION_DONE_IRQ_FLAG_O),
  .HOLD_CAPACITOR_CONNECT_O(HOLD_CAPACITOR_CONNECT_O), .RESULT_HIGH_BYTE_O(RESULT_HIGH_BYTE_O),
  .RESULT_LOW_BYTE_O(RESULT_LOW_BYTE_O));
`default_nettype wire
